//--- frag_gap_checker.sv
// Contract
// - Too-short submessage or bad inline parameter list marks fragment or gap invalid.
// - Reject fragment whose writer sequence number is not positive or unknown.
// - Reject fragment whose starting number is zero or beyond total fragment count.
// - Reject when fragment size exceeds data size or payload exceeds count times size.
// - Segment offset is (starting number minus one) times fragment size.
// - Segment length is payload size; reassembled length equals data size.
// - Expected fragments are data size over fragment size, rounded up.
// - Complete only when all expected fragments arrived; then deliver as plain data.
// - Inline parameters may appear on first or every fragment; tolerate both.
// - Reject gap whose first irrelevant sequence number is zero or negative.
// - Reject gap whose sequence-number set fails its own checks.
// - With group flag, reject gap whose group start or end is not positive.
// - With group flag, reject gap whose group end is below group start minus one.
// - Group start and end fields exist and are parsed only with group flag.
// - Irrelevant range runs from gap start to set base minus one inclusive.
// - Every number listed in the set bitmap is also irrelevant.
// - Writer identifier is source prefix joined with writer entity field.
// - Reader identifier is destination prefix joined with reader entity field.
// - Valid fragment or gap submessages leave the receiver context unchanged.
// - Fragment numbering starts at one; fragment size is sixteen bits.
`timescale 1ns/1ps
`include "frag_gap_defs.svh"

module frag_gap_checker (
    input  wire logic                  SYS_CLK,            // 200 MHz clock
    input  wire logic                  RESET,              // Async reset, active high
    input  wire logic                  CE,                 // Clock enable, freezes state low
    input  wire logic                  FRAG_VALID,         // Fragment submessage offered
    output wire logic                  FRAG_READY,         // Fragment can be taken this cycle
    input  wire logic                  FRAG_LEN_OK,        // Header length large enough
    input  wire logic                  FRAG_QOS_OK,        // Parameter list absent or valid
    input  wire logic [63:0]           FRAG_WRITER_SN,     // Writer sequence number
    input  wire logic [31:0]           FRAG_START_NUM,     // First fragment number
    input  wire logic [15:0]           FRAG_COUNT,         // Fragments in submessage
    input  wire logic [31:0]           FRAG_DATA_SIZE,     // Total data size, bytes
    input  wire logic [15:0]           FRAG_SIZE,          // Fragment size, bytes
    input  wire logic [31:0]           FRAG_PAYLOAD_LEN,   // Payload element size
    output wire logic                  SEG_VALID,          // Segment accepted pulse
    output wire logic [31:0]           SEG_OFFSET,         // Byte offset in buffer
    output wire logic [31:0]           SEG_LEN,            // Segment byte count
    output wire logic [63:0]           SEG_SN,             // Segment sequence number
    output wire logic                  FRAG_ERR,           // Invalid fragment pulse
    output wire logic                  REASM_DONE,         // Reassembly complete pulse
    output wire logic [63:0]           REASM_SN,           // Completed sequence number
    output wire logic [31:0]           REASM_LEN,          // Completed data length
    output wire logic [31:0]           EXP_FRAGS,          // Expected fragment count
    input  wire logic                  GAP_VALID,          // Gap submessage offered
    output wire logic                  GAP_READY,          // Gap can be taken this cycle
    input  wire logic                  GAP_LEN_OK,         // Header length large enough
    input  wire logic                  GAP_SET_OK,         // Number set passed its checks
    input  wire logic                  GAP_GROUP_FLAG,     // Group fields present
    input  wire logic [63:0]           GAP_START,          // First irrelevant number
    input  wire logic [63:0]           GAP_SET_BASE,       // Set bitmap base
    input  wire logic [8:0]            GAP_SET_NUM_BITS,   // Set bitmap length
    input  wire logic [255:0]          GAP_SET_BITMAP,     // Set bitmap, bit0 is base
    input  wire logic [63:0]           GAP_START_GSN,      // Group start number
    input  wire logic [63:0]           GAP_END_GSN,        // Group end number
    input  wire logic [31:0]           GAP_WRITER_ENT,     // Writer entity field
    input  wire logic [31:0]           GAP_READER_ENT,     // Reader entity field
    input  wire logic [95:0]           SRC_PREFIX,         // Receiver source prefix
    input  wire logic [95:0]           DST_PREFIX,         // Receiver destination prefix
    output wire logic                  GAP_OUT_VALID,      // Gap accepted pulse
    output wire logic                  GAP_ERR,            // Invalid gap pulse
    output wire logic [63:0]           GAP_RANGE_FIRST,    // Range first number
    output wire logic [63:0]           GAP_RANGE_LAST,     // Range last number
    output wire logic                  GAP_RANGE_NONEMPTY, // Range holds any number
    output wire logic [63:0]           GAP_LIST_BASE,      // Listed numbers base
    output wire logic [255:0]          GAP_LIST_BITS,      // Listed numbers, masked
    output wire logic [127:0]          WRITER_GUID,        // Writer identifier
    output wire logic [127:0]          READER_GUID         // Reader identifier
);
    import frag_gap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic sn_positive(input logic [63:0] x);
        sn_positive = !x[63] && (x != 64'h0);
    endfunction

    function automatic logic [`FRAG_CAP-1:0] frag_mask(input logic [31:0] first,
                                                      input logic [15:0] num,
                                                      input logic [31:0] total);
        logic [32:0] idx;
        logic [32:0] stop;
        frag_mask = '0;
        stop = {1'b0, first} + {17'h0, num};
        for (int i = 0; i < `FRAG_CAP; i++) begin
            idx = 33'(i) + 33'h1;
            frag_mask[i] = (idx >= {1'b0, first}) && (idx < stop) && (idx <= {1'b0, total});
        end
    endfunction

    function automatic logic [`FRAG_CNT_W-1:0] pop_count(input logic [`FRAG_CAP-1:0] m);
        pop_count = '0;
        for (int i = 0; i < `FRAG_CAP; i++) begin
            pop_count = pop_count + `FRAG_CNT_W'(m[i]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    ctx_t r;
    ctx_t n;

    logic                  take_frag;
    logic                  take_gap;

    assign take_frag = CE && (r.st == ST_IDLE) && FRAG_VALID;
    assign take_gap  = CE && (r.st == ST_IDLE) && !FRAG_VALID && GAP_VALID;
    assign FRAG_READY = CE && (r.st == ST_IDLE);
    assign GAP_READY  = CE && (r.st == ST_IDLE) && !FRAG_VALID;

    always_comb begin
        logic [32:0]          rem_sh;
        logic [31:0]          total;
        logic [31:0]          cap_bytes;
        logic [47:0]          off;
        logic                 bad;
        logic                 same;
        logic [`FRAG_CAP-1:0] new_map;
        logic [63:0]          last;
        rem_sh    = '0;
        total     = '0;
        cap_bytes = '0;
        off       = '0;
        bad       = 1'b0;
        same      = 1'b0;
        new_map   = '0;
        last      = '0;
        n = r;
        n.seg_valid = 1'b0;
        n.frag_err  = 1'b0;
        n.done      = 1'b0;
        n.gap_valid = 1'b0;
        n.gap_err   = 1'b0;
        unique case (r.st)
            ST_IDLE: begin
                if (FRAG_VALID) begin
                    n.sn     = FRAG_WRITER_SN;
                    n.start  = FRAG_START_NUM;
                    n.cnt    = FRAG_COUNT;
                    n.dsize  = FRAG_DATA_SIZE;
                    n.fsize  = FRAG_SIZE;
                    n.plen   = FRAG_PAYLOAD_LEN;
                    n.hdr_ok = FRAG_LEN_OK && FRAG_QOS_OK;
                    n.rem    = '0;
                    n.quo    = FRAG_DATA_SIZE;
                    n.step   = '0;
                    n.st     = ST_DIV;
                end else if (GAP_VALID) begin
                    bad = !GAP_LEN_OK || !GAP_SET_OK;
                    bad = bad || !sn_positive(GAP_START);
                    if (GAP_GROUP_FLAG) begin
                        bad = bad || !sn_positive(GAP_START_GSN) ||
                              !sn_positive(GAP_END_GSN);
                        bad = bad || ($signed(GAP_END_GSN) <
                                      $signed(GAP_START_GSN - 64'h1));
                    end
                    if (bad) begin
                        n.gap_err = 1'b1;
                    end else begin
                        last = GAP_SET_BASE - 64'h1;
                        n.gap_valid    = 1'b1;
                        n.gap_first    = GAP_START;
                        n.gap_last     = last;
                        n.gap_nonempty = $signed(GAP_START) <= $signed(last);
                        n.gap_base     = GAP_SET_BASE;
                        for (int i = 0; i < `SET_BITS; i++) begin
                            n.gap_bits[i] = GAP_SET_BITMAP[i] &&
                                            (`SET_NBITS_W'(i) < GAP_SET_NUM_BITS);
                        end
                        n.wguid = {SRC_PREFIX, GAP_WRITER_ENT};
                        n.rguid = {DST_PREFIX, GAP_READER_ENT};
                    end
                end
            end
            ST_DIV: begin
                // Restoring division of data size by fragment size
                rem_sh = {r.rem, r.quo[31]};
                if (rem_sh >= {17'h0, r.fsize}) begin
                    n.rem = 32'(rem_sh - {17'h0, r.fsize});
                    n.quo = {r.quo[30:0], 1'b1};
                end else begin
                    n.rem = rem_sh[31:0];
                    n.quo = {r.quo[30:0], 1'b0};
                end
                n.step = r.step + 6'h1;
                if (r.step == `DIV_LAST_STEP) begin
                    n.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                total = r.quo + {31'h0, |r.rem};
                cap_bytes = 32'(r.cnt) * 32'(r.fsize);
                bad = !r.hdr_ok;
                bad = bad || !sn_positive(r.sn) || (r.sn == `SN_UNKNOWN);
                bad = bad || (r.start == 32'h0) || (r.start > total);
                bad = bad || ({16'h0, r.fsize} > r.dsize) || (r.plen > cap_bytes);
                bad = bad || (r.fsize == 16'h0) || (total > 32'(`FRAG_CAP));
                same = r.rec_valid && (r.rec_sn == r.sn);
                new_map = (same ? r.rec_map : '0) | frag_mask(r.start, r.cnt, total);
                off = {16'h0, r.start - 32'h1} * {32'h0, r.fsize};
                if (bad) begin
                    n.frag_err = 1'b1;
                end else begin
                    n.seg_valid  = 1'b1;
                    n.seg_offset = off[31:0];
                    n.seg_len    = r.plen;
                    n.seg_sn     = r.sn;
                    n.exp_frags  = total;
                    if ({25'h0, pop_count(new_map)} == total) begin
                        n.done      = 1'b1;
                        n.done_sn   = r.sn;
                        n.done_len  = r.dsize;
                        n.rec_valid = 1'b0;
                        n.rec_map   = '0;
                    end else begin
                        n.rec_valid = 1'b1;
                        n.rec_sn    = r.sn;
                        n.rec_map   = new_map;
                    end
                end
                n.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            r <= CTX_RESET;
        end else if (CE) begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs; no receiver context is written by either path

    assign SEG_VALID          = r.seg_valid;
    assign SEG_OFFSET         = r.seg_offset;
    assign SEG_LEN            = r.seg_len;
    assign SEG_SN             = r.seg_sn;
    assign FRAG_ERR           = r.frag_err;
    assign REASM_DONE         = r.done;
    assign REASM_SN           = r.done_sn;
    assign REASM_LEN          = r.done_len;
    assign EXP_FRAGS          = r.exp_frags;
    assign GAP_OUT_VALID      = r.gap_valid;
    assign GAP_ERR            = r.gap_err;
    assign GAP_RANGE_FIRST    = r.gap_first;
    assign GAP_RANGE_LAST     = r.gap_last;
    assign GAP_RANGE_NONEMPTY = r.gap_nonempty;
    assign GAP_LIST_BASE      = r.gap_base;
    assign GAP_LIST_BITS      = r.gap_bits;
    assign WRITER_GUID        = r.wguid;
    assign READER_GUID        = r.rguid;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [47:0]           chk_off;
    logic [47:0]           chk_hi;
    logic [47:0]           chk_lo;

    assign chk_off = {16'h0, r.start - 32'h1} * {32'h0, r.fsize};
    assign chk_hi  = {16'h0, r.exp_frags} * {32'h0, r.fsize};
    assign chk_lo  = {16'h0, r.exp_frags - 32'h1} * {32'h0, r.fsize};

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    err_excl_a: assert property (!(r.frag_err && r.seg_valid))
        else $error("fragment error and segment together");
    seg_offset_a: assert property (r.seg_valid |-> r.seg_offset == chk_off[31:0])
        else $error("segment offset wrong");
    seg_len_a: assert property (r.seg_valid |-> r.seg_len == r.plen && r.seg_sn == r.sn)
        else $error("segment length wrong");
    sn_range_a: assert property (r.seg_valid |-> !r.sn[63] && r.sn != 64'h0)
        else $error("bad sequence number accepted");
    start_range_a: assert property (r.seg_valid |->
                                    r.start != 32'h0 && r.start <= r.exp_frags)
        else $error("starting fragment out of range");
    size_limit_a: assert property (r.seg_valid |-> {16'h0, r.fsize} <= r.dsize &&
                                   r.plen <= 32'(r.cnt) * 32'(r.fsize))
        else $error("size limits violated");
    exp_count_a: assert property (r.seg_valid |-> chk_hi >= {16'h0, r.dsize} &&
                                  chk_lo < {16'h0, r.dsize})
        else $error("expected fragment count wrong");
    done_seg_a: assert property (r.done |-> r.seg_valid && r.done_len == r.dsize)
        else $error("completion without segment");
    frag_lat_a: assert property (take_frag ##1 CE[*8] ##1 CE[*8] ##1 CE[*8] ##1
                                 CE[*8] ##1 CE |=> (r.seg_valid || r.frag_err))
        else $error("fragment answer late");
    ce_hold_a: assert property (!CE |=> $stable(r))
        else $error("state moved with enable low");
    gap_start_a: assert property (take_gap && !sn_positive(GAP_START) |=> r.gap_err)
        else $error("non-positive gap start accepted");
    gap_group_a: assert property (take_gap && GAP_GROUP_FLAG &&
                                  sn_positive(GAP_START_GSN) &&
                                  ($signed(GAP_END_GSN) < $signed(GAP_START_GSN - 64'h1))
                                  |=> r.gap_err && !r.gap_valid)
        else $error("group end below start accepted");
    gap_len_a: assert property (take_gap && !GAP_LEN_OK |=> r.gap_err)
        else $error("short gap accepted");
    gap_guid_a: assert property (take_gap |=> !r.gap_valid ||
                                 (r.wguid == {$past(SRC_PREFIX), $past(GAP_WRITER_ENT)} &&
                                  r.rguid == {$past(DST_PREFIX), $past(GAP_READER_ENT)}))
        else $error("gap identifiers wrong");
    gap_range_a: assert property (r.gap_valid |-> r.gap_last == r.gap_base - 64'h1)
        else $error("gap range end wrong");

    seg_seen_c: cover property (r.seg_valid && !r.done);
    done_seen_c: cover property (r.done);
    frag_err_c: cover property (r.frag_err);
    gap_group_c: cover property (take_gap && GAP_GROUP_FLAG ##1 r.gap_valid);
endmodule

//--- frag_gap_defs.svh
`ifndef FRAG_GAP_DEFS_SVH
`define FRAG_GAP_DEFS_SVH

// Reserved unknown sequence number (high word -1, low word 0)
`define SN_UNKNOWN      64'hffffffff_00000000
// Fragments tracked per sequence number in the reassembly record
`define FRAG_CAP        64
`define FRAG_CNT_W      7
// Iterative divider: one quotient bit per cycle
`define DIV_LAST_STEP   6'h1f
// Widest bitmap carried by a sequence-number set
`define SET_BITS        256
`define SET_NBITS_W     9

`endif

//--- frag_gap_pkg.sv
package frag_gap_pkg;
    `include "frag_gap_defs.svh"

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DIV   = 3'b010,
        ST_CHECK = 3'b100
    } state_t;

    typedef struct packed {
        state_t                  st;
        logic [63:0]             sn;
        logic [31:0]             start;
        logic [15:0]             cnt;
        logic [31:0]             dsize;
        logic [15:0]             fsize;
        logic [31:0]             plen;
        logic                    hdr_ok;
        logic [31:0]             rem;
        logic [31:0]             quo;
        logic [5:0]              step;
        logic                    rec_valid;
        logic [63:0]             rec_sn;
        logic [`FRAG_CAP-1:0]    rec_map;
        logic                    seg_valid;
        logic [31:0]             seg_offset;
        logic [31:0]             seg_len;
        logic [63:0]             seg_sn;
        logic                    frag_err;
        logic                    done;
        logic [63:0]             done_sn;
        logic [31:0]             done_len;
        logic [31:0]             exp_frags;
        logic                    gap_valid;
        logic                    gap_err;
        logic [63:0]             gap_first;
        logic [63:0]             gap_last;
        logic                    gap_nonempty;
        logic [63:0]             gap_base;
        logic [`SET_BITS-1:0]    gap_bits;
        logic [127:0]            wguid;
        logic [127:0]            rguid;
    } ctx_t;

    localparam ctx_t CTX_RESET = '{st: ST_IDLE, default: '0};
endpackage

//--- writer_model.sv
`timescale 1ns/1ps
module writer_model (
    input  wire logic         sys_clk,    // Bench clock
    input  wire logic         frag_ready, // Fragment path idle
    input  wire logic         gap_ready,  // Gap path idle
    output logic              frag_valid, // Fragment offered
    output logic [193:0]      fbus,       // Fragment fields
    output logic              gap_valid,  // Gap offered
    output logic [587:0]      gbus        // Gap fields
);
    initial begin
        frag_valid = 1'b0;
        gap_valid  = 1'b0;
        fbus       = '0;
        gbus       = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Offer, hold until taken, then scramble the released fields
    task automatic send_frag(input logic [193:0] f, output bit hung);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        fbus       = f;
        frag_valid = 1'b1;
        while (frag_ready !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        #1;
        frag_valid = 1'b0;
        fbus       = ~f;
        hung       = (n >= 100);
    endtask
    task automatic send_gap(input logic [587:0] g, output bit hung);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        gbus      = g;
        gap_valid = 1'b1;
        while (gap_ready !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        #1;
        gap_valid = 1'b0;
        gbus      = ~g;
        hung      = (n >= 100);
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "frag_gap_defs.svh"
module testbench;
    logic SYS_CLK, RESET, CE, FRAG_VALID, FRAG_READY, GAP_VALID, GAP_READY;
    logic FRAG_LEN_OK, FRAG_QOS_OK, GAP_LEN_OK, GAP_SET_OK, GAP_GROUP_FLAG;
    logic SEG_VALID, FRAG_ERR, REASM_DONE, GAP_OUT_VALID, GAP_ERR, GAP_RANGE_NONEMPTY;
    logic [15:0] FRAG_COUNT, FRAG_SIZE;
    logic [31:0] FRAG_START_NUM, FRAG_DATA_SIZE, FRAG_PAYLOAD_LEN, SEG_OFFSET, SEG_LEN;
    logic [31:0] REASM_LEN, EXP_FRAGS, GAP_WRITER_ENT, GAP_READER_ENT;
    logic [63:0] FRAG_WRITER_SN, SEG_SN, REASM_SN, GAP_START, GAP_SET_BASE, GAP_START_GSN;
    logic [63:0] GAP_END_GSN, GAP_RANGE_FIRST, GAP_RANGE_LAST, GAP_LIST_BASE;
    logic [8:0] GAP_SET_NUM_BITS;
    logic [255:0] GAP_SET_BITMAP, GAP_LIST_BITS;
    logic [95:0] SRC_PREFIX, DST_PREFIX;
    logic [127:0] WRITER_GUID, READER_GUID;
    logic [193:0] fbus;
    logic [587:0] gbus;
    logic [258:0] fq[$];
    logic [706:0] gq[$];
    logic [63:0] rec, rec_sn;
    int errors, checks;
    logic [63:0] s1;
    assign {FRAG_LEN_OK, FRAG_QOS_OK, FRAG_WRITER_SN, FRAG_START_NUM, FRAG_COUNT,
            FRAG_DATA_SIZE, FRAG_SIZE, FRAG_PAYLOAD_LEN} = fbus;
    assign {GAP_LEN_OK, GAP_SET_OK, GAP_GROUP_FLAG, GAP_START, GAP_SET_BASE, GAP_SET_NUM_BITS,
            GAP_SET_BITMAP, GAP_START_GSN, GAP_END_GSN, GAP_WRITER_ENT, GAP_READER_ENT} = gbus;
    frag_gap_checker DUT (.*);
    writer_model writer (.sys_clk(SYS_CLK), .frag_ready(FRAG_READY), .gap_ready(GAP_READY),
                         .frag_valid(FRAG_VALID), .fbus(fbus), .gap_valid(GAP_VALID),
                         .gbus(gbus));
    always #2.5 SYS_CLK = ~SYS_CLK;
    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [706:0] e, a);
        checks++;
        if (a !== e) begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic check_frag(input logic [258:0] a);
        cmp(fq.size() ? fq.pop_front() : 'x, a);
    endtask
    task automatic check_gap(input logic [706:0] a);
        cmp(gq.size() ? gq.pop_front() : 'x, a);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic frag(input bit lok, qok, input logic [63:0] sn, input logic [31:0] st,
                        input logic [15:0] cnt, input logic [31:0] ds, input logic [15:0] fs,
                        input logic [31:0] pl);
        logic [31:0] tot;
        bit err, done, hung;
        tot = (fs == 0) ? 0 : ds / fs + ((ds % fs) ? 1 : 0);
        err = !lok || !qok || $signed(sn) <= 0 || sn == `SN_UNKNOWN
            || st < 1 || st > tot || fs > ds || pl > cnt * fs
            || fs == 0 || tot > `FRAG_CAP;
        done = 1'b0;
        if (!err) begin
            if (sn !== rec_sn) begin
                rec_sn = sn;
                rec = '0;
            end
            for (int i = 0; i < cnt; i++) if (st + i <= tot) rec[st + i - 1] = 1'b1;
            done = (rec == ~({64{1'b1}} << tot));
            if (done) rec_sn = '0;
        end
        fq.push_back(err ? {3'b010, 256'h0} : {2'b10, done, (st - 1) * fs, pl, sn, tot,
                     done ? sn : 64'h0, done ? ds : 32'h0});
        writer.send_frag({lok, qok, sn, st, cnt, ds, fs, pl}, hung);
        if (hung) begin errors++; results(); end
    endtask
    task automatic gap(input bit lok, sok, fl, input logic [63:0] s, b, sg, eg);
        logic [8:0] nb;
        logic [255:0] bm;
        logic [31:0] we, re;
        bit err, hung;
        nb = 9'($urandom_range(256));
        for (int i = 0; i < 8; i++) bm[i * 32 +: 32] = $urandom();
        we = $urandom();
        re = $urandom();
        SRC_PREFIX = {3{$urandom()}};
        DST_PREFIX = {3{$urandom()}};
        err = !lok || !sok || $signed(s) <= 0
            || fl && ($signed(sg) <= 0 || $signed(eg) <= 0
            || $signed(eg) < $signed(sg) - 1);
        gq.push_back(err ? {2'b01, 705'h0} : {2'b10, s, b - 64'h1,
                     $signed(s) <= $signed(b - 64'h1), b, bm & ~({256{1'b1}} << nb),
                     SRC_PREFIX, we, DST_PREFIX, re});
        writer.send_gap({lok, sok, fl, s, b, nb, bm, sg, eg, we, re}, hung);
        if (hung) begin errors++; results(); end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge SYS_CLK) begin
        if (SEG_VALID === 1'b1 || FRAG_ERR === 1'b1)
            check_frag(FRAG_ERR ? {SEG_VALID, FRAG_ERR, REASM_DONE, 256'h0} :
                       {SEG_VALID, FRAG_ERR, REASM_DONE, SEG_OFFSET, SEG_LEN, SEG_SN, EXP_FRAGS,
                        REASM_DONE ? REASM_SN : 64'h0, REASM_DONE ? REASM_LEN : 32'h0});
        if (GAP_OUT_VALID === 1'b1 || GAP_ERR === 1'b1)
            check_gap(GAP_ERR ? {GAP_OUT_VALID, GAP_ERR, 705'h0} :
                      {GAP_OUT_VALID, GAP_ERR, GAP_RANGE_FIRST, GAP_RANGE_LAST,
                       GAP_RANGE_NONEMPTY, GAP_LIST_BASE, GAP_LIST_BITS,
                       WRITER_GUID, READER_GUID});
    end
    initial begin
        SYS_CLK = 1'b0;
        RESET = 1'b1;
        CE = 1'b1;
        SRC_PREFIX = '0;
        DST_PREFIX = '0;
        rec = '0;
        rec_sn = '0;
        void'($urandom(32'hdec9a2d7));
        s1 = 64'($urandom_range(32'h7fffffff, 1));
        repeat (8) @(posedge SYS_CLK);
        #1 RESET = 1'b0;
        // Malformed fragments, each refused
        frag(0, 1, s1, 1, 1, 1000, 300, 300);
        frag(1, 0, s1, 1, 1, 1000, 300, 300);
        frag(1, 1, 64'h0, 1, 1, 1000, 300, 300);
        frag(1, 1, {64{1'b1}}, 1, 1, 1000, 300, 300);
        frag(1, 1, `SN_UNKNOWN, 1, 1, 1000, 300, 300);
        frag(1, 1, s1, 0, 1, 1000, 300, 300);
        frag(1, 1, s1, 5, 1, 1000, 300, 100);
        frag(1, 1, s1, 1, 1, 1000, 1200, 100);
        frag(1, 1, s1, 1, 2, 1000, 300, 601);
        frag(1, 1, s1, 1, 1, 1000, 0, 0);
        frag(1, 1, s1, 1, 1, 65, 1, 1);
        $display("test fragment refusal done");
        // Reassembly with multi, duplicate, out of order and partial fragments
        frag(1, 1, s1, 1, 2, 1000, 300, 600);
        frag(1, 1, s1, 2, 1, 1000, 300, 300);
        frag(1, 1, s1, 4, 1, 1000, 300, 100);
        frag(1, 1, s1, 3, 1, 1000, 300, 300);
        frag(1, 1, s1 + 1, 1, 1, 600, 300, 300);
        frag(1, 1, s1 + 2, 2, 1, 600, 300, 300);
        frag(1, 1, s1 + 2, 1, 1, 600, 300, 300);
        frag(1, 1, s1 + 3, 1, 64, 64, 1, 64);
        // Freeze the divider for two cycles mid-computation
        #20 CE = 1'b0;
        #10 CE = 1'b1;
        $display("test reassembly done");
        // Gap validity boundaries, then random valid gaps
        gap(1, 1, 0, 10, 20, 0, 0);
        gap(1, 1, 0, 20, 20, {64{1'b1}}, 64'hfffffffffffffffb);
        gap(1, 1, 1, 5, 9, 100, 99);
        gap(1, 1, 1, 5, 9, 100, 98);
        gap(1, 1, 1, 5, 9, 0, 10);
        gap(1, 1, 1, 5, 9, 10, {64{1'b1}});
        gap(1, 1, 0, 0, 9, 1, 1);
        gap(1, 1, 0, {64{1'b1}}, 9, 1, 1);
        gap(0, 1, 0, 5, 9, 1, 1);
        gap(1, 0, 0, 5, 9, 1, 1);
        for (int i = 0; i < 20; i++) begin
            logic [63:0] s, b, sg;
            s = 64'($urandom_range(1000, 1));
            b = s + 64'($urandom_range(300));
            sg = 64'($urandom_range(5000, 1));
            gap(1, 1, 1'($urandom_range(1)), s, b, sg, sg + (b - s) + 64'($urandom_range(9)));
        end
        $display("test gap done");
        for (int i = 0; i < 100 && (fq.size() || gq.size()); i++) @(posedge SYS_CLK);
        if (fq.size() || gq.size()) errors++;
        results();
    end
endmodule
